//--- core/display_mem.sv
module display_mem
    import lcd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [4:0] wr_base,
    input wire logic [3:0] wr_lane_en,
    input wire logic [15:0] wr_mask,
    input wire logic [15:0] wr_data,
    input wire blink_op_e blk_op,
    input wire logic [4:0] blk_addr,
    input wire logic [3:0] blk_data,
    output logic [127:0] mem_flat,
    output logic [127:0] blink_flat
);
    logic [3:0] mem_reg [DEPTH];
    logic [3:0] blink_reg [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= 4'h0;
                blink_reg[i] <= 4'h0;
            end
        end else begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lane_en[l]) begin
                    // Lane addresses wrap past 31 to 0
                    mem_reg[lane_addr(wr_base, 2'(l))] <=
                        (mem_reg[lane_addr(wr_base, 2'(l))] & ~wr_mask[l*4 +: 4])
                        | (wr_data[l*4 +: 4] & wr_mask[l*4 +: 4]);
                end
            end
            case (blk_op)
                BLINK_WRITE: blink_reg[blk_addr] <= blk_data;
                BLINK_AND: blink_reg[blk_addr] <= blink_reg[blk_addr] & blk_data;
                BLINK_OR: blink_reg[blk_addr] <= blink_reg[blk_addr] | blk_data;
                default: ;
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_flat[i*4 +: 4] = mem_reg[i];
            blink_flat[i*4 +: 4] = blink_reg[i];
        end
    end
endmodule

//--- core/lcd_display_memory_timing.sv
module lcd_display_memory_timing
    import lcd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic data_valid,
    input wire logic [15:0] data_word,
    input wire logic decoder_used,
    input wire logic decoder_14seg,
    input wire logic nibble_write,
    input wire logic [3:0] nibble_value,
    input wire logic bit_write,
    input wire logic [1:0] bit_index,
    input wire logic bit_value,
    input wire logic ptr_load,
    input wire logic [4:0] ptr_load_value,
    input wire blink_op_e blink_op,
    input wire logic [3:0] blink_value,
    input wire logic blink_enable,
    input wire logic blink_rate_bit,
    input wire logic display_enable,
    input wire logic [1:0] division_count_field,
    input wire logic [1:0] frame_divider_field,
    input wire logic sync_n_in,
    output logic sync_n_out,
    output logic sync_n_oe,
    output logic [4:0] data_pointer,
    output logic [31:0] seg_drive,
    output logic [3:0] common_drive_outputs
);
    logic [2:0] cs_sync_reg;
    logic [2:0] ext_sync_reg;
    logic cs_fall;
    logic cs_rise;
    logic ext_resync;
    logic [4:0] ptr_reg;
    logic [4:0] ptr_next;
    logic [3:0] pack_en;
    logic [15:0] pack_mask;
    logic [15:0] pack_data;
    logic [4:0] pack_step;
    logic [3:0] wr_lane_en;
    logic [15:0] wr_mask;
    logic [15:0] wr_data;
    logic [4:0] wr_step;
    logic [127:0] mem_flat;
    logic [127:0] blink_flat;
    logic [127:0] shadow_mem_reg;
    logic [127:0] shadow_blink_reg;
    logic [127:0] latch_reg;
    logic [127:0] latch_next;
    logic [10:0] prescale_reg;
    logic [10:0] frame_mask;
    logic frame_tick;
    logic [1:0] com_idx_reg;
    logic [1:0] last_com;
    logic [16:0] blink_cnt_reg;
    logic blink_off;
    logic [31:0] seg_next;
    logic seg0_src;

    // Chip select and shared sync line come from pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cs_sync_reg <= 3'h7;
            ext_sync_reg <= 3'h7;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
            ext_sync_reg <= {ext_sync_reg[1:0], sync_n_in};
        end
    end
    assign cs_fall = cs_sync_reg[2] & ~cs_sync_reg[1];
    assign cs_rise = ~cs_sync_reg[2] & cs_sync_reg[1];
    // Another device pulled the shared line low while we were not
    assign ext_resync = ext_sync_reg[2] & ~ext_sync_reg[1] & ~sync_n_oe;

    // Pack a data word into up to four addresses by division count
    always_comb begin
        pack_en = 4'h0;
        pack_mask = 16'h0000;
        pack_data = 16'h0000;
        pack_step = STEP_FOUR;
        case (division_count_field)
            DIV_STATIC: begin
                pack_en = 4'hf;
                pack_mask = 16'h1111;
                pack_data = {3'h0, data_word[3], 3'h0, data_word[2],
                             3'h0, data_word[1], 3'h0, data_word[0]};
                pack_step = STEP_FOUR;
            end
            DIV_TWO: begin
                pack_en = 4'hf;
                pack_mask = 16'h3333;
                pack_data = {2'h0, data_word[7], data_word[6], 2'h0, data_word[5], data_word[4],
                             2'h0, data_word[3], data_word[2], 2'h0, data_word[1], data_word[0]};
                pack_step = STEP_FOUR;
            end
            DIV_THREE: begin
                pack_en = 4'h7;
                pack_mask = 16'h0777;
                pack_data = {4'h0, 2'h0, data_word[7:6], 1'b0, data_word[5:3],
                             1'b0, ~decoder_used & data_word[2], data_word[1:0]};
                pack_step = STEP_THREE;
            end
            default: begin
                if (decoder_used && decoder_14seg) begin
                    pack_en = 4'hf;
                    pack_mask = 16'hffff;
                    pack_data = {data_word[15:12], 1'b0, data_word[10:5], 1'b0, data_word[3:0]};
                    pack_step = STEP_FOUR;
                end else begin
                    pack_en = 4'h3;
                    pack_mask = 16'h00ff;
                    pack_data = {8'h00, data_word[7:4], ~decoder_used & data_word[3],
                                 data_word[2:0]};
                    pack_step = STEP_TWO;
                end
            end
        endcase
    end

    // Data bytes take priority over immediate nibble and bit commands
    always_comb begin
        wr_lane_en = 4'h0;
        wr_mask = 16'h0000;
        wr_data = 16'h0000;
        wr_step = 5'h00;
        if (data_valid) begin
            wr_lane_en = pack_en;
            wr_mask = pack_mask;
            wr_data = pack_data;
            wr_step = pack_step;
        end else if (nibble_write) begin
            wr_lane_en = 4'h1;
            wr_mask = 16'h000f;
            wr_data = {12'h000, nibble_value};
            wr_step = STEP_ONE;
        end else if (bit_write) begin
            wr_lane_en = 4'h1;
            wr_mask = {12'h000, 4'h1 << bit_index};
            wr_data = {12'h000, {4{bit_value}}};
        end
    end

    // Pointer: clear on select fall, then load, then advance
    always_comb begin
        if (cs_fall) begin
            ptr_next = 5'h00;
        end else if (ptr_load) begin
            ptr_next = ptr_load_value;
        end else begin
            ptr_next = ptr_reg + wr_step;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ptr_reg <= 5'h00;
        end else begin
            ptr_reg <= ptr_next;
        end
    end
    assign data_pointer = ptr_reg;

    display_mem u_mem (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_base(ptr_reg),
        .wr_lane_en(wr_lane_en),
        .wr_mask(wr_mask),
        .wr_data(wr_data),
        .blk_op(blink_op),
        .blk_addr(ptr_reg),
        .blk_data(blink_value),
        .mem_flat(mem_flat),
        .blink_flat(blink_flat)
    );

    // Snapshot on select rise; latch recombines it with the blink phase
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shadow_mem_reg <= '0;
            shadow_blink_reg <= '0;
        end else if (cs_rise) begin
            shadow_mem_reg <= mem_flat;
            shadow_blink_reg <= blink_flat;
        end
    end

    assign blink_off = blink_rate_bit ? blink_cnt_reg[BLINK_FAST_BIT]
                                      : blink_cnt_reg[BLINK_SLOW_BIT];
    assign latch_next = (blink_enable && blink_off)
                      ? (shadow_mem_reg & ~shadow_blink_reg)
                      : shadow_mem_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latch_reg <= '0;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Frame timing
    always_comb begin
        case (frame_divider_field)
            2'h0: frame_mask = FRAME_MASK_0;
            2'h1: frame_mask = FRAME_MASK_1;
            2'h2: frame_mask = FRAME_MASK_2;
            default: frame_mask = FRAME_MASK_3;
        endcase
        case (division_count_field)
            DIV_FOUR: last_com = LAST_COM_FOUR;
            DIV_THREE: last_com = LAST_COM_THREE;
            DIV_TWO: last_com = LAST_COM_TWO;
            default: last_com = LAST_COM_STATIC;
        endcase
    end
    assign frame_tick = (prescale_reg & frame_mask) == frame_mask;

    always_ff @(posedge sys_clk) begin
        if (rst || ext_resync) begin
            prescale_reg <= '0;
            com_idx_reg <= 2'h0;
            blink_cnt_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + 11'h001;
            blink_cnt_reg <= blink_cnt_reg + 17'h00001;
            if (frame_tick) begin
                com_idx_reg <= (com_idx_reg >= last_com) ? 2'h0 : com_idx_reg + 2'h1;
            end
        end
    end

    // Segment i at common c reads latch bit i*4+c
    always_comb begin
        for (int s = 0; s < SEG_COUNT; s++) begin
            seg_next[s] = display_enable & latch_reg[s*4 + int'(com_idx_reg)];
        end
    end
    assign seg0_src = latch_reg[com_idx_reg];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seg_drive <= 32'h00000000;
            common_drive_outputs <= 4'h0;
            sync_n_oe <= 1'b0;
        end else begin
            seg_drive <= seg_next;
            common_drive_outputs <= display_enable ? (4'h1 << com_idx_reg) : 4'h0;
            sync_n_oe <= display_enable && com_idx_reg == 2'h0;
        end
    end
    assign sync_n_out = 1'b0;

    chk_ptr_clear: assert property (@(posedge sys_clk) disable iff (rst)
        cs_fall |=> ptr_reg == 5'h00) else $error("pointer not cleared on select fall");

    chk_ptr_load: assert property (@(posedge sys_clk) disable iff (rst)
        (ptr_load && !cs_fall) |=> ptr_reg == $past(ptr_load_value))
        else $error("pointer load value lost");

    chk_static_step: assert property (@(posedge sys_clk) disable iff (rst)
        (data_valid && !ptr_load && !cs_fall && division_count_field == DIV_STATIC)
        |=> ptr_reg == 5'($past(ptr_reg) + 5'h04)) else $error("static step not four");

    chk_three_step: assert property (@(posedge sys_clk) disable iff (rst)
        (data_valid && !ptr_load && !cs_fall && division_count_field == DIV_THREE)
        |=> ptr_reg == 5'($past(ptr_reg) + 5'h03)) else $error("three-way step not three");

    chk_latch_copy: assert property (@(posedge sys_clk) disable iff (rst)
        cs_rise |=> shadow_mem_reg == $past(mem_flat)) else $error("memory not copied on rise");

    chk_blink_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (blink_enable && blink_off && !cs_rise) |=> (latch_reg & shadow_blink_reg) == '0)
        else $error("blinking bits shown in off half");

    chk_com_onehot: assert property (@(posedge sys_clk) disable iff (rst)
        display_enable ##1 display_enable |-> $onehot(common_drive_outputs))
        else $error("commons not one-hot");

    chk_com_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (!frame_tick && !ext_resync) |=> $stable(com_idx_reg))
        else $error("common stepped without frame tick");

    chk_seg_select: assert property (@(posedge sys_clk) disable iff (rst)
        display_enable |=> seg_drive[0] == $past(seg0_src))
        else $error("segment level differs from latch bit");
endmodule

//--- core/lcd_pkg.sv
package lcd_pkg;
    localparam int ADDR_W = 5;
    localparam int DEPTH = 32;
    localparam int NIB_W = 4;
    localparam int MEM_BITS = 128;
    localparam int SEG_COUNT = 32;
    localparam int COM_COUNT = 4;
    localparam int LANES = 4;

    // Division count field codes
    localparam logic [1:0] DIV_FOUR = 2'h0;
    localparam logic [1:0] DIV_STATIC = 2'h1;
    localparam logic [1:0] DIV_THREE = 2'h2;
    localparam logic [1:0] DIV_TWO = 2'h3;

    // Index of the last common in use per division count
    localparam logic [1:0] LAST_COM_FOUR = 2'h3;
    localparam logic [1:0] LAST_COM_THREE = 2'h2;
    localparam logic [1:0] LAST_COM_TWO = 2'h1;
    localparam logic [1:0] LAST_COM_STATIC = 2'h0;

    // Pointer advance per write kind
    localparam logic [4:0] STEP_ONE = 5'h01;
    localparam logic [4:0] STEP_TWO = 5'h02;
    localparam logic [4:0] STEP_THREE = 5'h03;
    localparam logic [4:0] STEP_FOUR = 5'h04;

    // Frame prescaler masks, 2^7, 2^8, 2^9, 2^11
    localparam int PRESCALE_W = 11;
    localparam logic [10:0] FRAME_MASK_0 = 11'h07f;
    localparam logic [10:0] FRAME_MASK_1 = 11'h0ff;
    localparam logic [10:0] FRAME_MASK_2 = 11'h1ff;
    localparam logic [10:0] FRAME_MASK_3 = 11'h7ff;

    // Blink period 2^17 or 2^16; the top bit of the period is the off half
    localparam int BLINK_W = 17;
    localparam int BLINK_SLOW_BIT = 16;
    localparam int BLINK_FAST_BIT = 15;

    typedef enum logic [1:0] {
        BLINK_NONE = 2'b00,
        BLINK_WRITE = 2'b01,
        BLINK_AND = 2'b10,
        BLINK_OR = 2'b11
    } blink_op_e;

    function automatic logic [4:0] lane_addr(input logic [4:0] base, input logic [1:0] lane);
        lane_addr = base + {3'h0, lane};
    endfunction
endpackage

//--- sim/lcd_panel.sv
module lcd_panel (
    input wire logic sys_clk,
    input wire logic [31:0] seg_drive,
    input wire logic [3:0] common_drive_outputs,
    output logic [127:0] image,
    output int frame_cycles
);
    timeunit 1ns;
    timeprecision 100ps;
    logic com0_reg = 1'b0;
    int count_reg = 0;
    // Segment state seen under each selected common
    always @(posedge sys_clk) begin
        for (int c = 0; c < 4; c++) begin
            if (common_drive_outputs == (4'h1 << c)) begin
                for (int s = 0; s < 32; s++) begin
                    image[s*4+c] <= seg_drive[s];
                end
            end
        end
        com0_reg <= common_drive_outputs[0];
        // Cycles between successive selections of common 0
        if (common_drive_outputs[0] && !com0_reg) begin
            frame_cycles <= count_reg;
            count_reg <= 1;
        end else begin
            count_reg <= count_reg + 1;
        end
    end
endmodule

//--- sim/test_lcd_display_memory_timing.sv
`define CHECK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module test_lcd_display_memory_timing
    import lcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst, cs_n, data_valid, decoder_used, decoder_14seg;
    logic nibble_write, bit_write, bit_value, ptr_load, blink_enable;
    logic blink_rate_bit, display_enable, sync_n_out, sync_n_oe;
    logic [15:0] data_word;
    logic [3:0] nibble_value, blink_value, common_drive_outputs;
    logic [1:0] bit_index, division_count_field, frame_divider_field;
    logic [4:0] ptr_load_value, data_pointer, exp_ptr;
    logic [31:0] seg_drive;
    logic [127:0] panel_image;
    logic [3:0] exp_mem [32];
    blink_op_e blink_op;
    logic ext_pull_n = 1'b1;
    // Shared line: our open-drain pull plus another device's pull
    wire sync_line = (sync_n_oe ? sync_n_out : 1'b1) & ext_pull_n;
    int frame_cycles;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    lcd_display_memory_timing u_dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n),
        .data_valid(data_valid), .data_word(data_word), .decoder_used(decoder_used),
        .decoder_14seg(decoder_14seg), .nibble_write(nibble_write),
        .nibble_value(nibble_value), .bit_write(bit_write), .bit_index(bit_index),
        .bit_value(bit_value), .ptr_load(ptr_load), .ptr_load_value(ptr_load_value),
        .blink_op(blink_op), .blink_value(blink_value), .blink_enable(blink_enable),
        .blink_rate_bit(blink_rate_bit), .display_enable(display_enable),
        .division_count_field(division_count_field),
        .frame_divider_field(frame_divider_field), .sync_n_in(sync_line),
        .sync_n_out(sync_n_out), .sync_n_oe(sync_n_oe), .data_pointer(data_pointer),
        .seg_drive(seg_drive), .common_drive_outputs(common_drive_outputs));

    lcd_panel u_panel (.sys_clk(sys_clk), .seg_drive(seg_drive),
        .common_drive_outputs(common_drive_outputs), .image(panel_image),
        .frame_cycles(frame_cycles));

    always #12.5 sys_clk = ~sys_clk;

    task automatic complete_run();
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cut a hung run short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic step(int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic load_ptr(logic [4:0] v);
        ptr_load = 1'b1;
        ptr_load_value = v;
        step(1);
        ptr_load = 1'b0;
        step(1);
        exp_ptr = v;
        `CHECK(data_pointer, v)
    endtask

    task automatic write_word(logic [15:0] w, logic dec, logic d14);
        logic [4:0] p;
        p = exp_ptr;
        data_valid = 1'b1;
        data_word = w;
        decoder_used = dec;
        decoder_14seg = d14;
        step(1);
        data_valid = 1'b0;
        case (division_count_field)
            DIV_STATIC: begin
                for (int i = 0; i < 4; i++) exp_mem[5'(p + i)][0] = w[i];
                exp_ptr = 5'(p + 4);
            end
            DIV_TWO: begin
                for (int i = 0; i < 4; i++) exp_mem[5'(p + i)][1:0] = {w[2*i+1], w[2*i]};
                exp_ptr = 5'(p + 4);
            end
            DIV_THREE: begin
                exp_mem[p][2:0] = {w[2] & !dec, w[1:0]};
                exp_mem[5'(p + 1)][2:0] = w[5:3];
                exp_mem[5'(p + 2)][2:0] = {1'b0, w[7:6]};
                exp_ptr = 5'(p + 3);
            end
            default: begin
                if (d14) begin
                    for (int i = 0; i < 4; i++) exp_mem[5'(p + i)] = w[4*i+:4];
                    exp_mem[5'(p + 2)][3] = 1'b0;
                    exp_mem[5'(p + 1)][0] = 1'b0;
                    exp_ptr = 5'(p + 4);
                end else begin
                    exp_mem[p] = {w[3] & !dec, w[2:0]};
                    exp_mem[5'(p + 1)] = w[7:4];
                    exp_ptr = 5'(p + 2);
                end
            end
        endcase
        step(1);
        `CHECK(data_pointer, exp_ptr)
    endtask

    task automatic wait_com(logic [3:0] v);
        int k;
        k = 0;
        while (common_drive_outputs !== v && k < 5000) begin
            step(1);
            k++;
        end
        `CHECK(common_drive_outputs, v)
    endtask

    task automatic test_reset();
        `CHECK(data_pointer, 5'h00)
        `CHECK(seg_drive, 32'h00000000)
        `CHECK(common_drive_outputs, 4'h0)
        `CHECK(sync_n_out, 1'b0)
    endtask

    task automatic test_modes();
        logic [1:0] divs [4];
        int sh [4];
        int cnt [4];
        logic [3:0] used [4];
        divs = '{DIV_FOUR, DIV_STATIC, DIV_THREE, DIV_TWO};
        sh = '{7, 8, 9, 11};
        cnt = '{4, 1, 3, 2};
        used = '{4'hf, 4'h1, 4'h7, 4'h3};
        for (int m = 0; m < 4; m++) begin
            division_count_field = divs[m];
            frame_divider_field = 2'(m);
            cs_n = 1'b0;
            step(8);
            `CHECK(data_pointer, 5'h00)
            load_ptr(5'h1e);
            write_word(16'h00a5, 1'b0, 1'b0);
            if (m == 0 || m == 2) write_word(16'h3c5f, 1'b1, 1'b0);
            if (m == 0) write_word(16'hbcf9, 1'b1, 1'b1);
            cs_n = 1'b1;
            step(3 * cnt[m] * (1 << sh[m]) + 100);
            for (int a = 0; a < 32; a++) begin
                `CHECK(panel_image[a*4+:4] & used[m], exp_mem[a] & used[m])
            end
            if (m != 1) begin
                `CHECK(frame_cycles, cnt[m] * (1 << sh[m]))
                wait_com(4'h1);
                step(4);
                `CHECK(sync_n_oe, 1'b1)
                wait_com(4'h2);
                step(4);
                `CHECK(sync_n_oe, 1'b0)
                // Another device pulls the line: commons restart at common 0
                ext_pull_n = 1'b0;
                step(4);
                `CHECK(common_drive_outputs, 4'h1)
                ext_pull_n = 1'b1;
            end
        end
    endtask

    task automatic test_blink();
        int k;
        division_count_field = DIV_FOUR;
        frame_divider_field = 2'h0;
        cs_n = 1'b0;
        step(8);
        load_ptr(5'h05);
        nibble_write = 1'b1;
        nibble_value = 4'hf;
        step(1);
        nibble_write = 1'b0;
        step(1);
        exp_mem[5] = 4'hf;
        `CHECK(data_pointer, 5'h06)
        bit_write = 1'b1;
        bit_value = 1'b1;
        step(1);
        bit_write = 1'b0;
        step(1);
        exp_mem[6][0] = 1'b1;
        `CHECK(data_pointer, 5'h06)
        load_ptr(5'h05);
        blink_value = 4'h3;
        blink_op = BLINK_WRITE;
        step(1);
        blink_value = 4'h4;
        blink_op = BLINK_OR;
        step(1);
        blink_value = 4'h6;
        blink_op = BLINK_AND;
        step(1);
        blink_op = BLINK_NONE;
        blink_rate_bit = 1'b1;
        blink_enable = 1'b1;
        cs_n = 1'b1;
        k = 0;
        while (panel_image[23:20] !== 4'h9 && k < 70000) begin
            step(1);
            k++;
        end
        `CHECK(panel_image[23:20], 4'h9)
        `CHECK(panel_image[27:24], exp_mem[6])
    endtask

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {cs_n, data_valid, decoder_used, decoder_14seg, nibble_write} = 5'h10;
        {bit_write, bit_value, ptr_load, blink_enable, blink_rate_bit} = 5'h00;
        {data_word, nibble_value, blink_value, bit_index} = 26'h0000000;
        {ptr_load_value, division_count_field, frame_divider_field} = 9'h000;
        display_enable = 1'b0;
        blink_op = BLINK_NONE;
        exp_ptr = 5'h00;
        exp_mem = '{default: 4'h0};
        step(2);
        rst = 1'b0;
        step(1);
        test_reset();
        display_enable = 1'b1;
        test_modes();
        test_blink();
        complete_run();
    end
endmodule
